// [logic/dba_regs.svh]
`ifndef DBA_REGS_SVH
`define DBA_REGS_SVH
`define DBA_OFS_ADDR        8'h20
`define DBA_OFS_LOCK        8'h86
`define DBA_PMB_LSB         0
`define DBA_PMB_MSB         6
`define DBA_REG_LSB         8
`define DBA_REG_MSB         14
`define DBA_LOCK_BIT        2
`define DBA_RST_REG_ADDR    7'h10
`define DBA_RST_PMB_ADDR    7'h40
`define DBA_RST_LOCK        1'b1
`define DBA_TEST_ADDR       7'h0a
`define DBA_NUM_PAGES       3'h5
`define DBA_CMD_PAGE        8'h00
`define DBA_IDLE_BYTE       8'hff
`endif

// [logic/dba_pkg.sv]
package dba_pkg;
  typedef enum logic [2:0] {
    DBA_IDLE  = 3'b000,
    DBA_ADDR  = 3'b001,
    DBA_ACK   = 3'b010,
    DBA_RX    = 3'b011,
    DBA_TX    = 3'b100,
    DBA_TXACK = 3'b101,
    DBA_TXLD  = 3'b110,
    DBA_IGN   = 3'b111
  } dba_state_e;
  typedef logic [6:0] dba_addr_t;
endpackage

// [logic/dba_sync.sv]
`timescale 1ns/10ps
module dba_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
        begin
          meta_q[i] <= 1'b1;
          dout[i]   <= 1'b1;
        end
        else
        begin
          meta_q[i] <= din[i];
          dout[i]   <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule

// [logic/dba_top.sv]
`timescale 1ns/10ps
`include "dba_regs.svh"
module dba_top
  import dba_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       test_mode,
  output logic [6:0]      reg_addr_q,
  output logic [6:0]      pmb_addr_q,
  output logic            addr_lock_q,
  output logic [2:0]      pmb_page_q,
  output logic [7:0]      pmb_byte_q,
  output logic            pmb_byte_vld_q,
  output logic            pmb_cmd_first_q
);
  logic [2:0] pin_s;
  logic       scl_s;
  logic       sda_s;
  logic       tst_s;
  logic       scl_p;
  logic       sda_p;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;

  dba_sync #(.WIDTH(3)) u_sync (
    .mclk (mclk),
    .nrst (nrst),
    .din  ({test_mode, sda_i, scl_i}),
    .dout (pin_s)
  );
  assign scl_s = pin_s[0];
  assign sda_s = pin_s[1];
  assign tst_s = pin_s[2];

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end
    else
    begin
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_p;
  assign scl_fall  = ~scl_s & scl_p;
  assign start_det = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;

  // register read mux, reserved bits read as zero
  function automatic logic [15:0] rd_word(input logic [7:0] ptr, input logic [6:0] ra,
                                          input logic [6:0] pa, input logic lk);
    logic [15:0] w;
    w = 16'h0000;
    if (ptr == `DBA_OFS_ADDR)
    begin
      w[`DBA_REG_MSB:`DBA_REG_LSB] = ra;
      w[`DBA_PMB_MSB:`DBA_PMB_LSB] = pa;
    end
    else if (ptr == `DBA_OFS_LOCK)
    begin
      w[`DBA_LOCK_BIT] = lk;
    end
    return w;
  endfunction

  dba_state_e state_q;
  logic [7:0] shift_q;
  logic [3:0] cnt_q;
  logic       rw_q;
  logic       mode_reg_q;
  logic [1:0] idx_q;
  logic       tx_hi_q;
  logic       rx_vld_q;
  logic [7:0] rx_byte_q;
  logic [7:0] ptr_q;
  logic [7:0] lo_q;
  logic       page_cmd_q;
  logic [7:0] tx_byte;
  logic [15:0] rd_val;
  logic [7:0] last_bit;
  logic       hit_reg;
  logic       hit_pmb;

  assign last_bit = {shift_q[6:0], sda_s};
  assign hit_reg = ((reg_addr_q != 7'h00) && (last_bit[7:1] == reg_addr_q))
                 || (tst_s && (last_bit[7:1] == `DBA_TEST_ADDR));
  assign hit_pmb = (pmb_addr_q != 7'h00) && (last_bit[7:1] == pmb_addr_q);
  assign rd_val  = rd_word(ptr_q, reg_addr_q, pmb_addr_q, addr_lock_q);
  assign tx_byte = !mode_reg_q ? `DBA_IDLE_BYTE : (tx_hi_q ? rd_val[15:8] : rd_val[7:0]);
  assign sda_o   = 1'b0;

  // bus engine: samples on scl rise, drives on scl fall
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q    <= DBA_IDLE;
      shift_q    <= 8'h00;
      cnt_q      <= 4'h0;
      rw_q       <= 1'b0;
      mode_reg_q <= 1'b0;
      sda_oe     <= 1'b0;
      idx_q      <= 2'h0;
      tx_hi_q    <= 1'b0;
      rx_vld_q   <= 1'b0;
      rx_byte_q  <= 8'h00;
    end
    else
    begin
      rx_vld_q <= 1'b0;
      if (start_det)
      begin
        state_q <= DBA_ADDR;
        cnt_q   <= 4'h0;
        sda_oe  <= 1'b0;
        idx_q   <= 2'h0;
        tx_hi_q <= 1'b0;
      end
      else if (stop_det)
      begin
        state_q <= DBA_IDLE;
        sda_oe  <= 1'b0;
      end
      else
      begin
        unique case (state_q)
          DBA_IDLE, DBA_IGN: sda_oe <= 1'b0;
          DBA_ADDR:
          begin
            if (scl_rise)
            begin
              shift_q <= last_bit;
              cnt_q   <= cnt_q + 4'h1;
              if (cnt_q == 4'h7)
              begin
                rw_q       <= sda_s;
                mode_reg_q <= hit_reg;
                state_q    <= (hit_reg || hit_pmb) ? DBA_ACK : DBA_IGN;
              end
            end
          end
          DBA_ACK:
          begin
            if (scl_fall)
            begin
              if (!sda_oe)
                sda_oe <= 1'b1;
              else if (rw_q)
              begin
                shift_q <= tx_byte;
                sda_oe  <= ~tx_byte[7];
                cnt_q   <= 4'h1;
                state_q <= DBA_TX;
              end
              else
              begin
                sda_oe  <= 1'b0;
                cnt_q   <= 4'h0;
                state_q <= DBA_RX;
              end
            end
          end
          DBA_RX:
          begin
            if (scl_rise)
            begin
              shift_q <= last_bit;
              cnt_q   <= cnt_q + 4'h1;
              if (cnt_q == 4'h7)
              begin
                rx_byte_q <= last_bit;
                rx_vld_q  <= 1'b1;
                state_q   <= DBA_ACK;
              end
            end
          end
          DBA_TX:
          begin
            if (scl_fall)
            begin
              if (cnt_q == 4'h8)
              begin
                sda_oe  <= 1'b0;
                tx_hi_q <= ~tx_hi_q;
                state_q <= DBA_TXACK;
              end
              else
              begin
                sda_oe  <= ~shift_q[6];
                shift_q <= {shift_q[6:0], 1'b0};
                cnt_q   <= cnt_q + 4'h1;
              end
            end
          end
          DBA_TXACK:
          begin
            if (scl_rise)
              state_q <= sda_s ? DBA_IGN : DBA_TXLD;
          end
          DBA_TXLD:
          begin
            if (scl_fall)
            begin
              shift_q <= tx_byte;
              sda_oe  <= ~tx_byte[7];
              cnt_q   <= 4'h1;
              state_q <= DBA_TX;
            end
          end
        endcase
        // the valid pulse lands while the engine already sits in the ack state
        if (rx_vld_q && (idx_q != 2'h3))
          idx_q <= idx_q + 2'h1;
      end
    end
  end

  // register writes: pointer, low byte, high byte commits
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ptr_q       <= 8'h00;
      lo_q        <= 8'h00;
      reg_addr_q  <= `DBA_RST_REG_ADDR;
      pmb_addr_q  <= `DBA_RST_PMB_ADDR;
      addr_lock_q <= `DBA_RST_LOCK;
    end
    else if (rx_vld_q && mode_reg_q)
    begin
      if (idx_q == 2'h0)
        ptr_q <= rx_byte_q;
      else if (idx_q == 2'h1)
        lo_q <= rx_byte_q;
      else if (idx_q == 2'h2)
      begin
        if ((ptr_q == `DBA_OFS_ADDR) && !addr_lock_q)
        begin
          reg_addr_q <= rx_byte_q[`DBA_REG_MSB-8:`DBA_REG_LSB-8];
          pmb_addr_q <= lo_q[`DBA_PMB_MSB:`DBA_PMB_LSB];
        end
        else if (ptr_q == `DBA_OFS_LOCK)
          addr_lock_q <= lo_q[`DBA_LOCK_BIT];
      end
    end
  end

  // command-bus byte stream and page selection
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pmb_byte_q      <= 8'h00;
      pmb_byte_vld_q  <= 1'b0;
      pmb_cmd_first_q <= 1'b0;
      pmb_page_q      <= 3'h0;
      page_cmd_q      <= 1'b0;
    end
    else
    begin
      pmb_byte_vld_q <= rx_vld_q && !mode_reg_q;
      if (rx_vld_q && !mode_reg_q)
      begin
        pmb_byte_q      <= rx_byte_q;
        pmb_cmd_first_q <= (idx_q == 2'h0);
        if (idx_q == 2'h0)
          page_cmd_q <= (rx_byte_q == `DBA_CMD_PAGE);
        else if ((idx_q == 2'h1) && page_cmd_q && (rx_byte_q[7:3] == 5'h00)
                 && (rx_byte_q[2:0] < `DBA_NUM_PAGES))
          pmb_page_q <= rx_byte_q[2:0];
      end
    end
  end
endmodule

// [tb/dba_host.sv]
`timescale 1ns/10ps
module dba_host (
  input  wire logic mclk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  // pull-up: released line reads high
  wire line = sda & !sda_oe;
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic go(input logic c, input logic d);
    @(posedge mclk);
    scl <= c;
    sda <= d;
    repeat (7) @(posedge mclk);
  endtask
  task automatic start;
    go(1'b0, sda);
    go(1'b0, 1'b1);
    go(1'b1, 1'b1);
    go(1'b1, 1'b0);
  endtask
  task automatic stop;
    go(1'b0, sda);
    go(1'b0, 1'b0);
    go(1'b1, 1'b0);
    go(1'b1, 1'b1);
  endtask
  // data moves only while scl is low
  task automatic bt(input logic b, output logic r);
    go(1'b0, sda);
    go(1'b0, b);
    go(1'b1, b);
    r = line;
  endtask
  task automatic xb(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic nk);
    for (int i = 7; i >= 0; i--)
      bt(d[i], q[i]);
    bt(ak, nk);
  endtask
endmodule

// [tb/dba_top_chk.sv]
`timescale 1ns/10ps
module dba_top_chk (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic [6:0] reg_addr_q,
  input wire logic [6:0] pmb_addr_q,
  input wire logic       addr_lock_q,
  input wire logic [2:0] pmb_page_q,
  input wire logic       pmb_byte_vld_q,
  input wire logic       pmb_cmd_first_q
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  sequence page_byte_s;
    pmb_byte_vld_q && !pmb_cmd_first_q;
  endsequence
  sequence byte_end_s;
    pmb_byte_vld_q ##1 !pmb_byte_vld_q;
  endsequence
  sda_const_a: assert property (sda_o == 1'b0)
    else $error("sda_o high");
  sda_chg_a: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda_oe moved with scl high");
  rst_vals_a: assert property ($rose(nrst) |-> addr_lock_q && reg_addr_q == 7'h10 && pmb_addr_q == 7'h40)
    else $error("bad reset values");
  lock_hold_a: assert property ($past(addr_lock_q) |-> $stable({reg_addr_q, pmb_addr_q}))
    else $error("address changed while locked");
  page_range_a: assert property (pmb_page_q < 3'h5)
    else $error("page out of range");
  page_src_a: assert property ($changed(pmb_page_q) |-> page_byte_s)
    else $error("page changed without data byte");
  vld_pulse_a: assert property (pmb_byte_vld_q |-> byte_end_s)
    else $error("byte valid too long");
  cmd_off_a: assert property (pmb_addr_q == 7'h00 |-> !pmb_byte_vld_q)
    else $error("byte taken with zero address");
endmodule
bind dba_top dba_top_chk u_chk (.mclk, .nrst, .scl_i, .sda_o, .sda_oe, .reg_addr_q, .pmb_addr_q,
  .addr_lock_q, .pmb_page_q, .pmb_byte_vld_q, .pmb_cmd_first_q);

// [tb/dba_top_tb.sv]
`timescale 1ns/10ps
module dba_top_tb;
  typedef struct packed {logic [6:0] a; logic [7:0] p; logic k; logic [15:0] d;} dba_row_s;
  logic        mclk, nrst, test_mode, scl, sda, sda_o, sda_oe, ak;
  logic        addr_lock_q, pmb_byte_vld_q, pmb_cmd_first_q;
  logic [6:0]  reg_addr_q, pmb_addr_q;
  logic [2:0]  pmb_page_q;
  logic [7:0]  pmb_byte_q;
  logic [15:0] rv;
  int          mismatches, checks_done;
  dba_row_s    rows [4] = '{'{7'h10, 8'h20, 1'b1, 16'h1040}, '{7'h10, 8'h86, 1'b1, 16'h0004},
                            '{7'h10, 8'h31, 1'b1, 16'h0000}, '{7'h0a, 8'h20, 1'b0, 16'h0000}};
  dba_host u_dba_host (.mclk, .sda_oe, .scl, .sda);
  dba_top u_dba_top (.mclk, .nrst, .scl_i(scl), .sda_i(sda & !sda_oe), .sda_o, .sda_oe,
    .test_mode, .reg_addr_q, .pmb_addr_q, .addr_lock_q, .pmb_page_q, .pmb_byte_q,
    .pmb_byte_vld_q, .pmb_cmd_first_q);
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic test_done;
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // md: 0 word write, 1 word read, 2 command plus one data byte
  task automatic xfer(input logic [6:0] a, input logic [7:0] p, input logic [1:0] md,
                      input logic [15:0] wd);
    logic [7:0] q;
    logic       nk;
    u_dba_host.start();
    u_dba_host.xb({a, 1'b0}, 1'b1, q, nk);
    ak = !nk;
    if (ak)
    begin
      u_dba_host.xb(p, 1'b1, q, nk);
      if (md == 2'd1)
      begin
        u_dba_host.start();
        u_dba_host.xb({a, 1'b1}, 1'b1, q, nk);
        u_dba_host.xb(8'hff, 1'b0, rv[7:0], nk);
        u_dba_host.xb(8'hff, 1'b1, rv[15:8], nk);
      end
      else
      begin
        u_dba_host.xb(wd[7:0], 1'b1, q, nk);
        if (md == 2'd0)
          u_dba_host.xb(wd[15:8], 1'b1, q, nk);
      end
    end
    u_dba_host.stop();
  endtask
  initial
  begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    test_done();
  end
  initial
  begin
    nrst = 1'b0;
    test_mode = 1'b0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    foreach (rows[i])
    begin
      xfer(rows[i].a, rows[i].p, 2'd1, 16'h0000);
      chk({15'h0, ak}, {15'h0, rows[i].k});
      if (rows[i].k)
        chk(rv, rows[i].d);
    end
    xfer(7'h10, 8'h20, 2'd0, 16'h3050);
    chk({1'b0, reg_addr_q, 1'b0, pmb_addr_q}, 16'h1040);
    xfer(7'h10, 8'h86, 2'd0, 16'h0000);
    chk({15'h0, addr_lock_q}, 16'h0000);
    // 0x30 and 0x50 stay clear of the reserved addresses
    xfer(7'h10, 8'h20, 2'd0, 16'h3050);
    chk({1'b0, reg_addr_q, 1'b0, pmb_addr_q}, 16'h3050);
    xfer(7'h10, 8'h20, 2'd1, 16'h0000);
    chk({15'h0, ak}, 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      xfer(7'h50, 8'h00, 2'd2, 16'(i));
      chk({13'h0, pmb_page_q}, (i < 5) ? 16'(i) : 16'h0004);
      chk({8'h00, pmb_byte_q}, 16'(i));
    end
    xfer(7'h30, 8'h20, 2'd0, 16'h3000);
    xfer(7'h50, 8'h00, 2'd2, 16'h0001);
    chk({15'h0, ak}, 16'h0000);
    @(posedge mclk) test_mode <= 1'b1;
    repeat (4) @(posedge mclk);
    xfer(7'h0a, 8'h20, 2'd1, 16'h0000);
    chk(rv, 16'h3000);
    xfer(7'h0a, 8'h20, 2'd0, 16'h0000);
    xfer(7'h00, 8'h20, 2'd1, 16'h0000);
    chk({15'h0, ak}, 16'h0000);
    xfer(7'h0a, 8'h20, 2'd1, 16'h1111);
    chk(rv, 16'h0000);
    @(posedge mclk) nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    chk({1'b0, reg_addr_q, 1'b0, pmb_addr_q}, 16'h1040);
    chk({15'h0, addr_lock_q}, 16'h0001);
    test_done();
  end
endmodule
